//--- fp_output_defs.vh
// Purpose: Constants for the frame pulse and output delay control block.
// Assumes: Byte-wide registers reached through a simple parallel byte port.
// Notes: Offsets are the device byte addresses; field layouts are local choices where none is printed.
`ifndef FP_OUTPUT_DEFS_VH
`define FP_OUTPUT_DEFS_VH
`define ADR_SYNTHA_OE 7'h36
`define ADR_SYNTHA_SQ 7'h37
`define ADR_SYNTHA_CP0 7'h3A
`define ADR_SYNTHA_CP1 7'h3C
`define ADR_SYNTHA_FD 7'h3D
`define ADR_PULSEA_RATE 7'h3E
`define ADR_PULSEA_SHAPE 7'h3F
`define ADR_PULSEA_FDL 7'h40
`define ADR_PULSEA_FDH 7'h41
`define ADR_PULSEA_FRM 7'h42
`define ADR_PULSEB_RATE 7'h43
`define ADR_PULSEB_SHAPE 7'h44
`define ADR_PULSEB_FDL 7'h45
`define ADR_PULSEB_FDH 7'h46
`define ADR_PULSEB_FRM 7'h47
`define ADR_SYNTHB_OE 7'h48
`define ADR_SYNTHB_SQ 7'h49
`define ADR_SYNTHB_CP0 7'h4C
`define ADR_SYNTHB_CP1 7'h4E
`define ADR_SYNTHB_FD 7'h4F
`define ADR_ETHER_OE 7'h50
`define ADR_ETHER_SQ 7'h51
`define ADR_ETHER_CP0 7'h53
`define ADR_ETHER_CP1 7'h54
`define ADR_ETHER_FD 7'h55
`define ADR_PRIMARY_OFS 7'h63
// Enable register fields: bit0/1 clock outputs, bit2/3 frame pulses, bit6 loop select, bit7 synthesizer on.
`define OE_CLK0 0
`define OE_CLK1 1
`define OE_FPA 2
`define OE_FPB 3
`define OE_LOOP 6
`define OE_RUN 7
// Squelch register fields: bits 0..3 run controls, bits 4..7 forced levels for the same outputs.
`define SQ_LEVEL 4
// Shape register fields.
`define SH_WIDTH_LSB 0
`define SH_STYLE 3
`define SH_FALL 4
`define SH_NEG 5
`define SH_LONG1HZ 6
`define SHAPE_SYNTH 3'h7
// Rate codes.
`define RATE_166 4'h0
`define RATE_400 4'h1
`define RATE_1K 4'h2
`define RATE_2K 4'h3
`define RATE_4K 4'h4
`define RATE_8K 4'h5
`define RATE_32K 4'h6
`define RATE_64K 4'h7
`define RATE_1HZ 4'h8
`define RATE_PPS 4'h9
// Timing in the 262.144 MHz pulse timebase.
`define TICK_HZ 262144000
`define FRAME_TICKS 32768
`define FINE_MAX 16'h7FFF
`define FRAME_MAX 7'h40
`define WIDTH_4MS_US 4000
`define WIDTH_PPS_NS 200
`define RESET_ZERO 8'h00
`define RESET_ETH 8'h83
`define RESET_SYN 8'h8F
`endif

//--- fp_output_ctrl.v
// Purpose: Frame pulse generation, squelch, disable and delay control for the output synthesizers.
// Assumes: clk is the 262.144 MHz pulse timebase; synthesizer clocks arrive as pins from other domains.
// Notes: Fine phase and coarse phase values are driven out to the analog phase shifters as registered words.
`timescale 1ns/1ps
`include "fp_output_defs.vh"
module fp_output_ctrl #(
  parameter integer FRAME_TICKS = `FRAME_TICKS,
  parameter integer SEC_TICKS = `TICK_HZ,
  parameter integer LONG_TICKS = 1048576
) (
  input wire clk,
  input wire rst_b,
  input wire regWrite,
  input wire regRead,
  input wire [6:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  input wire synthAClk0,
  input wire synthAClk1,
  input wire synthBClk0,
  input wire synthBClk1,
  input wire etherClk0,
  input wire etherClk1,
  input wire ppsIn,
  output reg [5:0] clkOut,
  output reg [5:0] clkOe,
  output reg [1:0] framePulse,
  output reg [1:0] framePulseOe,
  output reg etherSynthOn,
  output reg synthAOn,
  output reg synthBOn,
  output reg [8:0] etherPhase,
  output reg [8:0] synthAPhase,
  output reg [8:0] synthBPhase,
  output reg [11:0] coarsePhase
);
  localparam integer PPS_TICKS = (`WIDTH_PPS_NS * 262 + 999) / 1000;
  reg [7:0] regs_q [0:31];
  reg [2:0] syncA_q [0:5];
  reg [2:0] ppsSync_q;
  reg [7:0] fineLatch_q;
  wire [5:0] clkSync;
  integer i;
  function [4:0] slot;
    input [6:0] a;
    begin
      case (a)
        `ADR_SYNTHA_OE: slot = 5'd0;
        `ADR_SYNTHA_SQ: slot = 5'd1;
        `ADR_SYNTHA_CP0: slot = 5'd2;
        `ADR_SYNTHA_CP1: slot = 5'd3;
        `ADR_SYNTHA_FD: slot = 5'd4;
        `ADR_PULSEA_RATE: slot = 5'd5;
        `ADR_PULSEA_SHAPE: slot = 5'd6;
        `ADR_PULSEA_FDL: slot = 5'd7;
        `ADR_PULSEA_FDH: slot = 5'd8;
        `ADR_PULSEA_FRM: slot = 5'd9;
        `ADR_PULSEB_RATE: slot = 5'd10;
        `ADR_PULSEB_SHAPE: slot = 5'd11;
        `ADR_PULSEB_FDL: slot = 5'd12;
        `ADR_PULSEB_FDH: slot = 5'd13;
        `ADR_PULSEB_FRM: slot = 5'd14;
        `ADR_SYNTHB_OE: slot = 5'd15;
        `ADR_SYNTHB_SQ: slot = 5'd16;
        `ADR_SYNTHB_CP0: slot = 5'd17;
        `ADR_SYNTHB_CP1: slot = 5'd18;
        `ADR_SYNTHB_FD: slot = 5'd19;
        `ADR_ETHER_OE: slot = 5'd20;
        `ADR_ETHER_SQ: slot = 5'd21;
        `ADR_ETHER_CP0: slot = 5'd22;
        `ADR_ETHER_CP1: slot = 5'd23;
        `ADR_ETHER_FD: slot = 5'd24;
        `ADR_PRIMARY_OFS: slot = 5'd25;
        default: slot = 5'd31;
      endcase
    end
  endfunction
  // Combined phase word: primary offset always applies to the ether synthesizer, and to A and B only when primary-locked; sign extended to 9 bits.
  function [8:0] phaseSum;
    input [7:0] own;
    input [7:0] glob;
    input useGlob;
    begin
      phaseSum = {own[7], own} + (useGlob ? {glob[7], glob} : 9'h000);
    end
  endfunction
  wire [4:0] wSlot = slot(regAddr);
  wire [4:0] rSlot = slot(regAddr);
  // Multi-byte fine delay: low byte is buffered and both bytes land together on the high byte write.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 32; i = i + 1) begin
        regs_q[i] <= `RESET_ZERO;
      end
      regs_q[0] <= `RESET_SYN;
      regs_q[15] <= `RESET_SYN;
      regs_q[20] <= `RESET_ETH;
      fineLatch_q <= 8'h00;
    end else if (regWrite && wSlot != 5'd31) begin
      if (wSlot == 5'd7 || wSlot == 5'd12) begin
        fineLatch_q[7:0] <= regWdata;
      end else if (wSlot == 5'd8 || wSlot == 5'd13) begin
        regs_q[wSlot - 5'd1] <= fineLatch_q[7:0];
        regs_q[wSlot] <= (regWdata[7]) ? 8'h7F : regWdata;
      end else if (wSlot == 5'd9 || wSlot == 5'd14) begin
        regs_q[wSlot] <= (regWdata > {1'b0, `FRAME_MAX}) ? {1'b0, `FRAME_MAX} : regWdata;
      end else begin
        regs_q[wSlot] <= regWdata;
      end
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= (rSlot == 5'd31) ? 8'h00 : regs_q[rSlot];
    end
  end
  // Three-stage synchronisers; a change counts once stages two and three agree.
  reg [5:0] clkStable_q;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gSync
      wire raw = (g == 0) ? synthAClk0 : (g == 1) ? synthAClk1 : (g == 2) ? synthBClk0 :
                 (g == 3) ? synthBClk1 : (g == 4) ? etherClk0 : etherClk1;
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          syncA_q[g] <= 3'b000;
          clkStable_q[g] <= 1'b0;
        end else begin
          syncA_q[g] <= {syncA_q[g][1:0], raw};
          if (syncA_q[g][1] == syncA_q[g][2]) begin
            clkStable_q[g] <= syncA_q[g][2];
          end
        end
      end
    end
  endgenerate
  assign clkSync = clkStable_q;
  reg ppsStable_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ppsSync_q <= 3'b000;
      ppsStable_q <= 1'b0;
    end else begin
      ppsSync_q <= {ppsSync_q[1:0], ppsIn};
      if (ppsSync_q[1] == ppsSync_q[2]) begin
        ppsStable_q <= ppsSync_q[2];
      end
    end
  end
  // Frame pulse engines: a free frame counter, then coarse and fine delay, then width and shaping.
  reg [31:0] period_q [0:1];
  reg [31:0] phaseCnt_q [0:1];
  reg [31:0] widthCnt_q [0:1];
  reg [1:0] pulseRaw_q;
  reg [1:0] ppsPrev_q;
  reg [1:0] clkPrev_q;
  function [31:0] ratePeriod;
    input [3:0] code;
    begin
      case (code)
        `RATE_166: ratePeriod = 48 * FRAME_TICKS;
        `RATE_400: ratePeriod = 20 * FRAME_TICKS;
        `RATE_1K: ratePeriod = 8 * FRAME_TICKS;
        `RATE_2K: ratePeriod = 4 * FRAME_TICKS;
        `RATE_4K: ratePeriod = 2 * FRAME_TICKS;
        `RATE_8K: ratePeriod = FRAME_TICKS;
        `RATE_32K: ratePeriod = FRAME_TICKS / 4;
        `RATE_64K: ratePeriod = FRAME_TICKS / 8;
        default: ratePeriod = SEC_TICKS;
      endcase
    end
  endfunction
  function [31:0] shapeWidth;
    input [2:0] code;
    begin
      case (code)
        3'h0: shapeWidth = 64;
        3'h1: shapeWidth = 32;
        3'h2: shapeWidth = 16;
        3'h3: shapeWidth = 8;
        3'h4: shapeWidth = 4;
        default: shapeWidth = 1;
      endcase
    end
  endfunction
  generate
    for (g = 0; g < 2; g = g + 1) begin : gPulse
      wire [7:0] rate = regs_q[5 + 5 * g];
      wire [7:0] shape = regs_q[6 + 5 * g];
      wire [15:0] fine = {regs_q[8 + 5 * g], regs_q[7 + 5 * g]};
      wire [7:0] frames = regs_q[9 + 5 * g];
      wire [31:0] per = ratePeriod(rate[3:0]);
      wire [31:0] offs = {16'h0000, fine} + frames * FRAME_TICKS;
      // The delay only moves the phase; a delay longer than the period wraps instead of stretching it.
      wire [31:0] offsMod = offs % per;
      wire synClk = clkSync[0];
      wire isPps = (rate[3:0] == `RATE_PPS);
      wire is1Hz = (rate[3:0] == `RATE_1HZ);
      // Synthesizer-clock widths count synthesizer edges, and the pin only moves on those edges,
      // so the pulse spans exactly one clock period whatever its phase to the frame counter.
      wire synPaced = !isPps && !shape[`SH_STYLE] && shape[2:0] == `SHAPE_SYNTH && !(is1Hz && shape[`SH_LONG1HZ]);
      wire synAligned = !isPps && (is1Hz || shape[2:0] == `SHAPE_SYNTH);
      wire synEdge = shape[`SH_FALL] ? (clkPrev_q[g] & ~synClk) : (~clkPrev_q[g] & synClk);
      wire fire = isPps ? (ppsStable_q & ~ppsPrev_q[g]) : (phaseCnt_q[g] == offsMod);
      wire [31:0] wid = isPps ? PPS_TICKS : is1Hz && shape[`SH_LONG1HZ] ? LONG_TICKS :
                        shape[`SH_STYLE] ? (per >> 1) : shapeWidth(shape[2:0]);
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          phaseCnt_q[g] <= 32'h00000000;
          widthCnt_q[g] <= 32'h00000000;
          period_q[g] <= 32'h00000000;
          pulseRaw_q[g] <= 1'b0;
          ppsPrev_q[g] <= 1'b0;
          clkPrev_q[g] <= 1'b0;
        end else begin
          ppsPrev_q[g] <= ppsStable_q;
          clkPrev_q[g] <= synClk;
          period_q[g] <= per;
          phaseCnt_q[g] <= (phaseCnt_q[g] + 32'h1 >= period_q[g]) ? 32'h0 : phaseCnt_q[g] + 32'h1;
          if (fire) begin
            widthCnt_q[g] <= wid;
          end else if (widthCnt_q[g] != 32'h0 && (!synPaced || synEdge)) begin
            widthCnt_q[g] <= widthCnt_q[g] - 32'h1;
          end
          if (!synAligned || synEdge) begin
            pulseRaw_q[g] <= (widthCnt_q[g] != 32'h0) ^ shape[`SH_NEG];
          end
        end
      end
    end
  endgenerate
  // Output stage: enable clears first, so a disabled output floats even if also squelched.
  wire [7:0] oeA = regs_q[0];
  wire [7:0] sqA = regs_q[1];
  wire [7:0] oeB = regs_q[15];
  wire [7:0] sqB = regs_q[16];
  wire [7:0] oeE = regs_q[20];
  wire [7:0] sqE = regs_q[21];
  wire [5:0] runBit = {sqE[1:0], sqB[1:0], sqA[1:0]};
  wire [5:0] lvlBit = {sqE[5:4], sqB[5:4], sqA[5:4]};
  wire [5:0] enBit = {oeE[1:0] & {2{oeE[`OE_RUN]}}, oeB[1:0] & {2{oeB[`OE_RUN]}},
                      oeA[1:0] & {2{oeA[`OE_RUN]}}};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clkOut <= 6'h00;
      clkOe <= 6'h00;
      framePulse <= 2'h0;
      framePulseOe <= 2'h0;
      etherSynthOn <= 1'b0;
      synthAOn <= 1'b0;
      synthBOn <= 1'b0;
      etherPhase <= 9'h000;
      synthAPhase <= 9'h000;
      synthBPhase <= 9'h000;
      coarsePhase <= 12'h000;
    end else begin
      clkOe <= enBit;
      clkOut <= (clkSync & runBit) | (lvlBit & ~runBit);
      framePulseOe <= oeA[`OE_FPB:`OE_FPA] & {2{oeA[`OE_RUN]}};
      framePulse <= (pulseRaw_q & sqA[3:2]) | (sqA[7:6] & ~sqA[3:2]);
      etherSynthOn <= oeE[`OE_RUN];
      synthAOn <= oeA[`OE_RUN];
      synthBOn <= oeB[`OE_RUN];
      etherPhase <= phaseSum(regs_q[24], regs_q[25], 1'b1);
      synthAPhase <= phaseSum(regs_q[4], regs_q[25], ~oeA[`OE_LOOP]);
      synthBPhase <= phaseSum(regs_q[19], regs_q[25], ~oeB[`OE_LOOP]);
      coarsePhase <= {regs_q[23][1:0], regs_q[22][1:0], regs_q[18][1:0], regs_q[17][1:0],
                      regs_q[3][1:0], regs_q[2][1:0]};
    end
  end
endmodule // fp_output_ctrl

//--- fp_output_ctrl_properties.sv
// Purpose: Port-level checks for the frame pulse and output delay control block.
// Assumes: A register write shows at the outputs two edges later.
// Notes: Read-back checks rely on a read two edges after the write, with one idle edge between.
`timescale 1ns/1ps
`include "fp_output_defs.vh"
module fp_output_ctrl_properties #(
  parameter integer FRAME_TICKS = 64,
  parameter integer SEC_TICKS = 2048,
  parameter integer LONG_TICKS = 4096
) (
  input wire clk,
  input wire rst_b,
  input wire regWrite,
  input wire regRead,
  input wire [6:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  input wire [5:0] clkOut,
  input wire [5:0] clkOe,
  input wire [1:0] framePulseOe,
  input wire etherSynthOn,
  input wire [11:0] coarsePhase
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  fine_clamp_a: assert property (regWrite && regAddr == `ADR_PULSEA_FDH
    ##2 regRead && regAddr == `ADR_PULSEA_FDH
    |=> regRdata == (($past(regWdata, 3) > 8'h7F) ? 8'h7F : $past(regWdata, 3)))
    else $error("fine delay high byte not clamped");
  frame_clamp_a: assert property (regWrite && regAddr == `ADR_PULSEA_FRM
    ##2 regRead && regAddr == `ADR_PULSEA_FRM
    |=> regRdata == (($past(regWdata, 3) > 8'h40) ? 8'h40 : $past(regWdata, 3)))
    else $error("frame delay not clamped");
  offset_readback_a: assert property (regWrite && regAddr == `ADR_PRIMARY_OFS
    ##2 regRead && regAddr == `ADR_PRIMARY_OFS
    |=> regRdata == $past(regWdata, 3))
    else $error("primary offset read back wrong");
  synth_a_enable_a: assert property (regWrite && regAddr == `ADR_SYNTHA_OE && regWdata[7]
    |-> ##2 {framePulseOe, clkOe[1:0]} == $past(regWdata[3:0], 2))
    else $error("synth a output enables wrong");
  ether_enable_a: assert property (regWrite && regAddr == `ADR_ETHER_OE && regWdata[7]
    |-> ##2 clkOe[5:4] == $past(regWdata[1:0], 2))
    else $error("ether output enables wrong");
  ether_power_a: assert property (regWrite && regAddr == `ADR_ETHER_OE |-> ##2 etherSynthOn == $past(regWdata[7], 2))
    else $error("ether synth power wrong");
  squelch_level_a: assert property (regWrite && regAddr == `ADR_SYNTHA_SQ && !regWdata[0]
    |-> ##2 clkOut[0] == $past(regWdata[4], 2))
    else $error("squelched clock level wrong");
  coarse_phase_a: assert property (regWrite && regAddr == `ADR_SYNTHA_CP0
    |-> ##2 coarsePhase[1:0] == $past(regWdata[1:0], 2))
    else $error("coarse phase not applied");
endmodule // fp_output_ctrl_properties
bind fp_output_ctrl fp_output_ctrl_properties #(.FRAME_TICKS(FRAME_TICKS), .SEC_TICKS(SEC_TICKS),
  .LONG_TICKS(LONG_TICKS)) chk (.clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .clkOut(clkOut), .clkOe(clkOe),
  .framePulseOe(framePulseOe), .etherSynthOn(etherSynthOn), .coarsePhase(coarsePhase));

//--- output_sink_model.sv
// Purpose: Downstream pins fed by the clock and frame pulse outputs.
// Assumes: No pull resistors on the output nets.
// Notes: A floating pin flips every cycle so a stale level never looks valid.
`timescale 1ns/1ps
module output_sink_model (
  input wire clk,
  input wire [1:0] framePulse,
  input wire [1:0] framePulseOe,
  input wire [5:0] clkOut,
  input wire [5:0] clkOe,
  output logic [1:0] fpPin,
  output logic [5:0] clkPin
);
  logic [7:0] last = 8'h00;
  always @(posedge clk) last <= {fpPin, clkPin};
  always_comb begin
    fpPin = (framePulseOe & framePulse) | (~framePulseOe & ~last[7:6]);
    clkPin = (clkOe & clkOut) | (~clkOe & ~last[5:0]);
  end
endmodule // output_sink_model

//--- tb.sv
// Purpose: Self-checking bench for the frame pulse and output delay control block.
// Assumes: Outputs settle two edges after a register write.
// Notes: Frame and second counts are shrunk through parameters to keep every rate short.
`timescale 1ns/1ps
`include "fp_output_defs.vh"
module tb;
  localparam integer F = 64;
  localparam integer S = 2048;
  // 200 ns of the 262.144 MHz timebase, rounded up to whole ticks.
  localparam integer PPS_W = 53;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] div = 8'h00;
  logic ppsIn = 1'b0;
  logic [7:0] rdv;
  int errors = 0;
  int total_checks = 0;
  wire [7:0] regRdata;
  wire [5:0] clkOut, clkOe, clkPin;
  wire [1:0] framePulse, framePulseOe, fpPin;
  wire etherSynthOn, synthAOn, synthBOn;
  wire [8:0] etherPhase, synthAPhase, synthBPhase;
  wire [11:0] coarsePhase;
  fp_output_ctrl #(.FRAME_TICKS(F), .SEC_TICKS(S), .LONG_TICKS(4096)) dut (.clk(clk), .rst_b(rst_b),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .synthAClk0(div[1]), .synthAClk1(div[1]), .synthBClk0(div[1]), .synthBClk1(div[2]), .etherClk0(div[0]),
    .etherClk1(div[2]), .ppsIn(ppsIn), .clkOut(clkOut), .clkOe(clkOe), .framePulse(framePulse),
    .framePulseOe(framePulseOe), .etherSynthOn(etherSynthOn), .synthAOn(synthAOn), .synthBOn(synthBOn),
    .etherPhase(etherPhase), .synthAPhase(synthAPhase), .synthBPhase(synthBPhase), .coarsePhase(coarsePhase));
  output_sink_model sink (.clk(clk), .framePulse(framePulse), .framePulseOe(framePulseOe), .clkOut(clkOut),
    .clkOe(clkOe), .fpPin(fpPin), .clkPin(clkPin));
  initial forever #5 clk = ~clk;
  always @(negedge clk) div <= div + 8'h01;
  task report_and_stop;
    begin
      if (errors == 0 && total_checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        errors++;
        $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    begin
      regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      @(negedge clk);
      regWrite = 1'b0;
      // An idle edge keeps the strobe from falling and rising again in one time step.
      @(negedge clk);
    end
  endtask
  task rd_chk(input logic [6:0] a, input logic [7:0] exp);
    begin
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      chk(regRdata, exp);
      @(negedge clk);
    end
  endtask
  // Cycles between two rising edges of pulse B at the pin; the first gap after a change is discarded.
  task gap(output int n);
    int k, seen;
    logic prv;
    begin
      n = 0;
      seen = 0;
      prv = fpPin[1];
      for (k = 0; k < 9000 && seen < 2; k++) begin
        @(negedge clk);
        if (fpPin[1] && !prv) seen++;
        if (seen == 1) n++;
        prv = fpPin[1];
      end
    end
  endtask
  task t_reset;
    begin
      rd_chk(`ADR_SYNTHA_OE, 8'h8F);
      rd_chk(`ADR_SYNTHB_OE, 8'h8F);
      rd_chk(`ADR_ETHER_OE, 8'h83);
      rd_chk(`ADR_PRIMARY_OFS, 8'h00);
      rd_chk(`ADR_PULSEA_FRM, 8'h00);
      wr(7'h38, 8'h55);
      rd_chk(7'h38, 8'h00);
    end
  endtask
  task t_rate;
    int n, c;
    int expGap [9];
    begin
      expGap = '{48 * F, 20 * F, 8 * F, 4 * F, 2 * F, F, F / 4, F / 8, S};
      wr(`ADR_SYNTHA_SQ, 8'h0F);
      wr(`ADR_PULSEB_SHAPE, 8'h07);
      for (c = 0; c < 9; c++) begin
        wr(`ADR_PULSEB_RATE, c[7:0]);
        gap(n);
        gap(n);
        chk(n, expGap[c]);
      end
    end
  endtask
  task t_shape;
    int i, k, hi;
    logic [7:0] shp [4];
    int expHi [4];
    begin
      shp = '{8'h07, 8'h27, 8'h0F, 8'h03};
      expHi = '{4, F - 4, F / 2, 8};
      wr(`ADR_PULSEB_RATE, {4'h0, `RATE_8K});
      for (i = 0; i < 4; i++) begin
        wr(`ADR_PULSEB_SHAPE, shp[i]);
        repeat (4 * F) @(negedge clk);
        hi = 0;
        for (k = 0; k < F; k++) begin
          @(negedge clk);
          if (fpPin[1] === 1'b1) hi++;
        end
        chk(hi, expHi[i]);
      end
    end
  endtask
  task t_pps;
    int k, hi;
    begin
      wr(`ADR_PULSEB_SHAPE, 8'h00);
      wr(`ADR_PULSEB_RATE, {4'h0, `RATE_PPS});
      repeat (16) @(negedge clk);
      hi = 0;
      ppsIn = 1'b1;
      for (k = 0; k < 200; k++) begin
        @(negedge clk);
        if (k == 100) ppsIn = 1'b0;
        if (fpPin[1] === 1'b1) hi++;
      end
      chk(hi, PPS_W);
    end
  endtask
  task t_squelch;
    begin
      wr(`ADR_SYNTHA_SQ, 8'hA0);
      wr(`ADR_SYNTHB_SQ, 8'h20);
      wr(`ADR_ETHER_SQ, 8'h10);
      repeat (3) @(negedge clk);
      chk({framePulse, clkOut}, {2'b10, 6'b011010});
      repeat (2) @(negedge clk);
      chk({framePulse, clkOut}, {2'b10, 6'b011010});
    end
  endtask
  task t_disable;
    logic p;
    begin
      wr(`ADR_SYNTHA_OE, 8'h8A);
      wr(`ADR_SYNTHB_OE, 8'h8D);
      wr(`ADR_ETHER_OE, 8'h82);
      repeat (3) @(negedge clk);
      chk({framePulseOe, clkOe}, {2'b10, 6'b100110});
      p = clkPin[0];
      @(negedge clk);
      chk(clkPin[0] ^ p, 1'b1);
      wr(`ADR_SYNTHA_OE, 8'h0F);
      wr(`ADR_SYNTHB_OE, 8'h0F);
      wr(`ADR_ETHER_OE, 8'h03);
      repeat (3) @(negedge clk);
      chk({etherSynthOn, synthAOn, synthBOn}, 3'b000);
      wr(`ADR_SYNTHA_OE, 8'h8F);
      wr(`ADR_SYNTHB_OE, 8'h8F);
      wr(`ADR_ETHER_OE, 8'h83);
      repeat (3) @(negedge clk);
      chk({etherSynthOn, synthAOn, synthBOn}, 3'b111);
    end
  endtask
  task t_phase;
    begin
      wr(`ADR_PRIMARY_OFS, 8'h80);
      rd_chk(`ADR_PRIMARY_OFS, 8'h80);
      wr(`ADR_SYNTHA_FD, 8'h7F);
      wr(`ADR_SYNTHB_OE, 8'hCF);
      wr(`ADR_SYNTHB_FD, 8'h05);
      wr(`ADR_ETHER_FD, 8'h80);
      wr(`ADR_SYNTHA_CP0, 8'h01);
      wr(`ADR_SYNTHA_CP1, 8'h02);
      wr(`ADR_SYNTHB_CP0, 8'h03);
      wr(`ADR_SYNTHB_CP1, 8'h00);
      wr(`ADR_ETHER_CP0, 8'h02);
      wr(`ADR_ETHER_CP1, 8'h01);
      repeat (3) @(negedge clk);
      chk(synthAPhase, 9'h1FF);
      chk(synthBPhase, 9'h005);
      chk(etherPhase, 9'h100);
      chk(coarsePhase, 12'h639);
    end
  endtask
  task t_delay;
    begin
      wr(`ADR_PULSEA_FDL, 8'h34);
      wr(`ADR_PULSEA_FDH, 8'hFF);
      rd_chk(`ADR_PULSEA_FDH, 8'h7F);
      rd_chk(`ADR_PULSEA_FDL, 8'h34);
      wr(`ADR_PULSEA_FRM, 8'hFF);
      rd_chk(`ADR_PULSEA_FRM, 8'h40);
      wr(`ADR_PULSEB_FRM, 8'h40);
      rd_chk(`ADR_PULSEB_FRM, 8'h40);
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset;
    t_rate;
    t_shape;
    t_pps;
    t_squelch;
    t_disable;
    t_phase;
    t_delay;
    report_and_stop;
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    report_and_stop;
  end
endmodule // tb
